//--- tb/mecim_bank_chk.sv
// Checker bound to the maintenance register bank
`timescale 1ns/10ps
module mecim_chk (
  // Clock, reset, register port
  input wire core_clk,
  input wire nrst,
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire [7:0] reg_wdata,
  // Observed outputs
  input wire bipolar_violation_inject,
  input wire pattern_error_inject,
  input wire excess_zero_rule_select,
  input wire counter_report_mode,
  input wire irq_n
);
  reg [7:0] m3;
  reg [7:0] m4;
  reg [7:0] m5;
  wire w3 = reg_wr && reg_addr == 8'h13;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // Shadows of written register values
  always @(posedge core_clk or negedge nrst)
    if (!nrst)
    begin
      m3 <= 8'h00;
      m4 <= 8'hff;
      m5 <= 8'hff;
    end
    else if (reg_wr)
    begin
      if (reg_addr == 8'h13)
        m3 <= reg_wdata;
      if (reg_addr == 8'h14)
        m4 <= reg_wdata;
      if (reg_addr == 8'h15)
        m5 <= reg_wdata;
    end
  property p_bv_rise;
    w3 && reg_wdata[6] && !m3[6] |-> ##2 bipolar_violation_inject;
  endproperty
  a_bv_rise: assert property (p_bv_rise) else $error("no violation");
  property p_bv_hold;
    w3 && reg_wdata[6] && m3[6] |-> ##2 !bipolar_violation_inject;
  endproperty
  a_bv_hold: assert property (p_bv_hold) else $error("extra violation");
  property p_bv_one;
    bipolar_violation_inject |=> !bipolar_violation_inject;
  endproperty
  a_bv_one: assert property (p_bv_one) else $error("long violation");
  property p_pe_rise;
    w3 && reg_wdata[5] && !m3[5] |-> ##2 pattern_error_inject;
  endproperty
  a_pe_rise: assert property (p_pe_rise) else $error("no error");
  property p_pe_one;
    pattern_error_inject |=> !pattern_error_inject;
  endproperty
  a_pe_one: assert property (p_pe_one) else $error("long error");
  property p_zrule;
    excess_zero_rule_select == m3[4];
  endproperty
  a_zrule: assert property (p_zrule) else $error("rule select wrong");
  property p_mode;
    counter_report_mode == m3[1];
  endproperty
  a_mode: assert property (p_mode) else $error("report mode wrong");
  property p_mask;
    &m4 && &m5 |-> irq_n;
  endproperty
  a_mask: assert property (p_mask) else $error("masked irq seen");
endmodule // mecim_chk
bind mecim_bank mecim_chk u_chk (.core_clk(core_clk), .nrst(nrst),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
  .bipolar_violation_inject(bipolar_violation_inject),
  .pattern_error_inject(pattern_error_inject),
  .excess_zero_rule_select(excess_zero_rule_select),
  .counter_report_mode(counter_report_mode), .irq_n(irq_n));

//--- tb/test_maint_error_counter_irq_masks.sv
// Self-checking bench for the maintenance register bank
`timescale 1ns/10ps
module test_maint_error_counter_irq_masks;
  reg core_clk, nrst, reg_wr, reg_rd;
  reg [7:0] reg_addr, reg_wdata, q;
  reg [4:0] line_event;
  reg [7:1] error_event;
  reg [3:0] cnt_in;
  reg [5:0] seen;
  wire [7:0] reg_rdata;
  wire viol_pulse, pei, zero_rule, mode, irq_n;
  integer fails, n_tests, i, k;
  integer cyc = 0;
  mecim_bank u_dut (.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .line_event(line_event),
    .error_event(error_event), .pattern_logic_error(cnt_in[0]),
    .excess_zeros(cnt_in[1]), .code_violation(cnt_in[2]),
    .one_second_tick(cnt_in[3]), .bipolar_violation_inject(viol_pulse),
    .pattern_error_inject(pei), .excess_zero_rule_select(zero_rule),
    .counter_report_mode(mode), .irq_n(irq_n));
  initial
  begin
    core_clk = 0;
    forever #12.5 core_clk = ~core_clk;
  end
  task chk(input string nm, input [7:0] s, input [7:0] e);
  begin
    n_tests = n_tests + 1;
    if (s !== e)
    begin
      fails = fails + 1;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  end
  endtask
  task wrap_up;
  begin
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  end
  endtask
  task wr(input [7:0] a, input [7:0] d);
  begin
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge core_clk);
    reg_wr = 1'b0;
  end
  endtask
  task rd(input [7:0] a);
  begin
    @(negedge core_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge core_clk);
    reg_rd = 1'b0;
    q = reg_rdata;
  end
  endtask
  task inj(input [7:0] d, input [5:0] e);
  begin
    wr(8'h13, d);
    for (i = 0; i < 3; i = i + 1)
    begin
      @(negedge core_clk);
      seen = {seen[3:0], viol_pulse, pei};
    end
    chk("inject", {2'h0, seen}, {2'h0, e});
  end
  endtask
  task cnt(input [7:0] c, input [3:0] s, input integer n, input [15:0] e);
  begin
    wr(8'h13, c);
    @(negedge core_clk);
    cnt_in = s;
    repeat (n) @(negedge core_clk);
    cnt_in = 4'h0;
    wr(8'h13, c | 8'h01);
    rd(8'h1b);
    chk("count low", q, e[7:0]);
    rd(8'h1c);
    chk("count high", q, e[15:8]);
    wr(8'h13, c);
  end
  endtask
  task pulse(input [11:0] e);
  begin
    @(negedge core_clk);
    {error_event, line_event} = e;
    @(negedge core_clk);
    {error_event, line_event} = 12'h000;
  end
  endtask
  task irq_t(input [7:0] ma, input [7:0] pa, input [7:0] m, input [11:0] e);
  begin
    pulse(e);
    chk("irq_n masked", {7'h00, irq_n}, 8'h01);
    rd(pa);
    wr(ma, ~m);
    pulse(e);
    chk("irq_n", {7'h00, irq_n}, 8'h00);
    rd(pa);
    chk("pending", q, m);
    chk("irq_n cleared", {7'h00, irq_n}, 8'h01);
    wr(ma, 8'hff);
  end
  endtask
  always @(posedge core_clk)
  begin
    cyc = cyc + 1;
    if (cyc == 80000)
    begin
      fails = fails + 1;
      wrap_up;
    end
  end
  initial
  begin
    {nrst, reg_wr, reg_rd, reg_addr, reg_wdata} = 19'h00000;
    {line_event, error_event, cnt_in, fails, n_tests} = 0;
    repeat (2) @(negedge core_clk);
    nrst = 1'b1;
    rd(8'h13);
    chk("control reset", q, 8'h00);
    rd(8'h14);
    chk("line mask reset", q, 8'hff);
    rd(8'h15);
    chk("error mask reset", q, 8'hff);
    $display("test reset done");
    inj(8'h40, 6'h20);
    inj(8'h40, 6'h00);
    inj(8'h60, 6'h10);
    inj(8'h00, 6'h00);
    inj(8'h60, 6'h30);
    wr(8'h13, 8'h12);
    chk("rule select", {7'h00, zero_rule}, 8'h01);
    chk("report mode", {7'h00, mode}, 8'h01);
    rd(8'h13);
    chk("control readback", q, 8'h12);
    $display("test inject done");
    for (k = 0; k < 5; k = k + 1)
      irq_t(8'h14, 8'h19, 8'h01 << k, 12'h001 << k);
    for (k = 1; k < 8; k = k + 1)
      irq_t(8'h15,8'h1a,8'h01<<k,12'h010<<k);
    $display("test masks done");
    wr(8'h13, 8'h02);
    @(negedge core_clk);
    cnt_in = 4'h1;
    repeat (3) @(negedge core_clk);
    cnt_in = 4'h8;
    @(negedge core_clk);
    cnt_in = 4'h0;
    rd(8'h1b);
    chk("auto count", q, 8'h03);
    cnt(8'h00, 4'h9, 2, 16'h0002);
    cnt(8'h04, 4'h3, 5, 16'h0005);
    cnt(8'h08, 4'h2, 3, 16'h0000);
    cnt(8'h0c, 4'h2, 3, 16'h0003);
    cnt(8'h0c, 4'h4, 2, 16'h0002);
    wr(8'h13, 8'h01);
    @(negedge core_clk);
    cnt_in = 4'h1;
    repeat (2) @(negedge core_clk);
    cnt_in = 4'h0;
    wr(8'h13, 8'h01);
    rd(8'h1b);
    chk("held transfer", q, 8'h00);
    wr(8'h13, 8'h00);
    wr(8'h13, 8'h01);
    rd(8'h1b);
    chk("new transfer", q, 8'h02);
    wr(8'h15, 8'hfe);
    cnt(8'h00, 4'h1, 65540, 16'hffff);
    chk("overflow irq_n", {7'h00, irq_n}, 8'h00);
    rd(8'h1a);
    chk("overflow pending", q, 8'h01);
    wr(8'h15, 8'hff);
    $display("test counter done");
    wrap_up;
  end
endmodule // test_maint_error_counter_irq_masks

//--- verilog/mecim_bank.v
// Maintenance control, error counter and interrupt mask register bank
`timescale 1ns/10ps
`include "mecim_defines.vh"

// Behaviour
// - Rising edge of bipolar violation inject gives one violation pulse.
// - Rising edge of pattern error inject corrupts one pattern bit.
// - Two-bit source select picks what the 16-bit counter counts.
// - Counter report mode: 0 manual, 1 automatic.
// - In manual mode, rising transfer bit copies count to results, then clears counter.
// - Line mask bit 4 gates pattern sync interrupt, resets 1.
// - Line mask bit 3 gates transmit clock loss interrupt, resets 1.
// - Line mask bit 2 gates driver fault interrupt, resets 1.
// - Line mask bit 1 gates alarm signal interrupt, resets 1.
// - Line mask bit 0 gates signal loss; upper bits reset 111.
// - Error mask bit 7 gates shaper overflow interrupt, resets 1.
// - Error mask bit 6 gates jitter buffer overflow, resets 1.
// - Error mask bit 5 gates jitter buffer underflow, resets 1.
// - Error mask bit 4 gates pattern logic error, resets 1.
// - Error mask bit 3 gates excess zeros interrupt, resets 1.
// - Error mask bit 2 gates code violation interrupt, resets 1.
// - Error mask bit 1 gates one-second tick interrupt, resets 1.
// - Error mask bit 0 gates counter overflow interrupt, resets 1.
// - Reading the event register clears it and withdraws the request.
module mecim_bank (
  // Clock and reset
  input wire core_clk,
  input wire nrst,
  // Register port
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  // Line event sources, one-cycle pulses, bits 4..0
  input wire [4:0] line_event,
  // Error event sources, one-cycle pulses, bits 7..1
  input wire [7:1] error_event,
  // Error detector pulses
  input wire pattern_logic_error,
  input wire excess_zeros,
  input wire code_violation,
  // Auto report tick from one-second timer
  input wire one_second_tick,
  // Transmit path controls
  output reg bipolar_violation_inject,
  output reg pattern_error_inject,
  output wire excess_zero_rule_select,
  output wire counter_report_mode,
  // Interrupt request, active low level
  output wire irq_n
);

  reg [7:0] maintenance_error_control;
  reg [7:0] line_event_irq_mask;
  reg [7:0] error_event_irq_mask;
  reg [7:0] line_pending;
  reg [7:0] error_pending;
  reg [15:0] error_count;
  reg [15:0] count_result;
  reg prev_viol;
  reg prev_err;
  reg prev_trf;
  reg count_inc;
  reg transfer;
  reg overflow;
  wire [1:0] count_source;
  wire [7:0] line_set;
  wire [7:0] error_set;
  reg [7:0] next_rdata;
  reg [7:0] next_maint;
  reg [7:0] next_line_mask;
  reg [7:0] next_err_mask;
  reg [15:0] next_error_count;
  reg [15:0] next_count_result;
  wire viol_rise;
  wire perr_rise;
  wire xfer_rise;
  wire wr_maint;
  wire wr_line_mask;
  wire wr_err_mask;
  wire rd_line_event;
  wire rd_error_event;
  wire pattern_sync_irq_mask;
  wire tx_clock_loss_irq_mask;
  wire driver_fault_irq_mask;
  wire alarm_signal_irq_mask;
  wire signal_loss_irq_mask;
  wire shaper_overflow_irq_mask;
  wire jitter_buffer_overflow_irq_mask;
  wire jitter_buffer_underflow_irq_mask;
  wire pattern_error_irq_mask;
  wire excess_zero_irq_mask;
  wire code_violation_irq_mask;
  wire one_second_tick_irq_mask;
  wire counter_overflow_irq_mask;
  wire [7:0] line_request;
  wire [7:0] error_request;

  ////////////////////////////////////////////////////////////////////////////
  // Control fields

  assign excess_zero_rule_select =
    maintenance_error_control[`MECIM_BIT_ZERO_RULE];
  assign counter_report_mode = maintenance_error_control[`MECIM_BIT_CNT_MODE];
  assign count_source =
    maintenance_error_control[`MECIM_SRC_HI:`MECIM_SRC_LO];

  // Rising edges of the strobe bits
  assign viol_rise =
    maintenance_error_control[`MECIM_BIT_VIOL_INJ] & ~prev_viol;
  assign perr_rise =
    maintenance_error_control[`MECIM_BIT_PERR_INJ] & ~prev_err;
  assign xfer_rise =
    maintenance_error_control[`MECIM_BIT_XFER] & ~prev_trf;

  // Register access decode
  assign wr_maint = reg_wr && (reg_addr == `MECIM_ADDR_MAINT);
  assign wr_line_mask = reg_wr && (reg_addr == `MECIM_ADDR_LINE_MASK);
  assign wr_err_mask = reg_wr && (reg_addr == `MECIM_ADDR_ERR_MASK);
  assign rd_line_event = reg_rd && (reg_addr == `MECIM_ADDR_EVENT);
  assign rd_error_event = reg_rd && (reg_addr == `MECIM_ADDR_EVENT_ERR);

  ////////////////////////////////////////////////////////////////////////////
  // Named interrupt mask fields

  assign pattern_sync_irq_mask = line_event_irq_mask[4];
  assign tx_clock_loss_irq_mask = line_event_irq_mask[3];
  assign driver_fault_irq_mask = line_event_irq_mask[2];
  assign alarm_signal_irq_mask = line_event_irq_mask[1];
  assign signal_loss_irq_mask = line_event_irq_mask[0];
  assign shaper_overflow_irq_mask = error_event_irq_mask[7];
  assign jitter_buffer_overflow_irq_mask = error_event_irq_mask[6];
  assign jitter_buffer_underflow_irq_mask = error_event_irq_mask[5];
  assign pattern_error_irq_mask = error_event_irq_mask[4];
  assign excess_zero_irq_mask = error_event_irq_mask[3];
  assign code_violation_irq_mask = error_event_irq_mask[2];
  assign one_second_tick_irq_mask = error_event_irq_mask[1];
  assign counter_overflow_irq_mask = error_event_irq_mask[0];

  ////////////////////////////////////////////////////////////////////////////
  // Register writes and mask registers

  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      maintenance_error_control <= `MECIM_RST_MAINT;
      line_event_irq_mask <= `MECIM_RST_LINE_MASK;
      error_event_irq_mask <= `MECIM_RST_ERR_MASK;
    end
    else
    begin
      maintenance_error_control <= next_maint;
      line_event_irq_mask <= next_line_mask;
      error_event_irq_mask <= next_err_mask;
    end
  end

  // Next register values, unmapped writes leave all unchanged
  always @*
  begin
    next_maint = maintenance_error_control;
    next_line_mask = line_event_irq_mask;
    next_err_mask = error_event_irq_mask;
    if (wr_maint)
      next_maint = reg_wdata;
    if (wr_line_mask)
      next_line_mask = reg_wdata;
    if (wr_err_mask)
      next_err_mask = reg_wdata;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Edge detection of inject and transfer bits

  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      prev_viol <= 1'b0;
      prev_err <= 1'b0;
      prev_trf <= 1'b0;
      bipolar_violation_inject <= 1'b0;
      pattern_error_inject <= 1'b0;
    end
    else
    begin
      prev_viol <= maintenance_error_control[`MECIM_BIT_VIOL_INJ];
      prev_err <= maintenance_error_control[`MECIM_BIT_PERR_INJ];
      prev_trf <= maintenance_error_control[`MECIM_BIT_XFER];
      bipolar_violation_inject <= viol_rise;
      // one pattern error per rising edge
      pattern_error_inject <= perr_rise;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Error counter

  always @*
  begin
    case (count_source)
      `MECIM_SRC_PATTERN: count_inc = pattern_logic_error;
      `MECIM_SRC_ZEROS: count_inc = excess_zeros;
      `MECIM_SRC_CODE: count_inc = code_violation;
      `MECIM_SRC_BOTH: count_inc = code_violation | excess_zeros;
      default: count_inc = 1'b0;
    endcase
  end

  // transfer on rising edge; auto mode uses timer tick
  always @*
  begin
    if (counter_report_mode)
      transfer = one_second_tick;
    else
      transfer = xfer_rise;
  end

  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      error_count <= 16'h0000;
      count_result <= 16'h0000;
      overflow <= 1'b0;
    end
    else
    begin
      overflow <= count_inc & ~transfer & (error_count == 16'hffff);
      error_count <= next_error_count;
      count_result <= next_count_result;
    end
  end

  // copy then clear counter, count saturates
  always @*
  begin
    next_error_count = error_count;
    next_count_result = count_result;
    if (transfer)
    begin
      next_count_result = error_count;
      // Event in the transfer cycle starts the new count
      next_error_count = {15'h0000, count_inc};
    end
    else if (count_inc && (error_count != 16'hffff))
      next_error_count = error_count + 16'h0001;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt pending bits, cleared by read

  // Unmasked line events latch
  assign line_set = {
    3'h0,
    line_event[4] & ~pattern_sync_irq_mask,
    line_event[3] & ~tx_clock_loss_irq_mask,
    line_event[2] & ~driver_fault_irq_mask,
    line_event[1] & ~alarm_signal_irq_mask,
    line_event[0] & ~signal_loss_irq_mask
  };
  // Unmasked error events latch
  assign error_set = {
    error_event[7] & ~shaper_overflow_irq_mask,
    error_event[6] & ~jitter_buffer_overflow_irq_mask,
    error_event[5] & ~jitter_buffer_underflow_irq_mask,
    error_event[4] & ~pattern_error_irq_mask,
    error_event[3] & ~excess_zero_irq_mask,
    error_event[2] & ~code_violation_irq_mask,
    error_event[1] & ~one_second_tick_irq_mask,
    overflow & ~counter_overflow_irq_mask
  };

  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      line_pending <= 8'h00;
      error_pending <= 8'h00;
    end
    else
    begin
      if (rd_line_event)
        line_pending <= line_set;
      else
        line_pending <= line_pending | line_set;
      if (rd_error_event)
        error_pending <= error_set;
      else
        error_pending <= error_pending | error_set;
    end
  end

  // Masking a pending bit withdraws its request
  assign line_request = line_pending & ~line_event_irq_mask;
  assign error_request = error_pending & ~error_event_irq_mask;
  assign irq_n = ~(|line_request | |error_request);

  ////////////////////////////////////////////////////////////////////////////
  // Read data

  always @*
  begin
    case (reg_addr)
      `MECIM_ADDR_MAINT: next_rdata = maintenance_error_control;
      `MECIM_ADDR_LINE_MASK: next_rdata = line_event_irq_mask;
      `MECIM_ADDR_ERR_MASK: next_rdata = error_event_irq_mask;
      `MECIM_ADDR_EVENT: next_rdata = line_pending;
      `MECIM_ADDR_EVENT_ERR: next_rdata = error_pending;
      `MECIM_ADDR_CNT_A: next_rdata = count_result[7:0];
      `MECIM_ADDR_CNT_B: next_rdata = count_result[15:8];
      default: next_rdata = 8'h00;
    endcase
  end

  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= next_rdata;
  end

endmodule // mecim_bank

//--- verilog/mecim_defines.vh
// Register offsets, field positions and reset values of the maintenance bank
`ifndef MECIM_DEFINES_VH
`define MECIM_DEFINES_VH
`define MECIM_ADDR_MAINT 8'h13
`define MECIM_ADDR_LINE_MASK 8'h14
`define MECIM_ADDR_ERR_MASK 8'h15
`define MECIM_ADDR_EVENT 8'h19
`define MECIM_ADDR_EVENT_ERR 8'h1a
`define MECIM_ADDR_CNT_A 8'h1b
`define MECIM_ADDR_CNT_B 8'h1c
`define MECIM_BIT_VIOL_INJ 6
`define MECIM_BIT_PERR_INJ 5
`define MECIM_BIT_ZERO_RULE 4
`define MECIM_SRC_HI 3
`define MECIM_SRC_LO 2
`define MECIM_BIT_CNT_MODE 1
`define MECIM_BIT_XFER 0
`define MECIM_SRC_PATTERN 2'h0
`define MECIM_SRC_ZEROS 2'h1
`define MECIM_SRC_CODE 2'h2
`define MECIM_SRC_BOTH 2'h3
`define MECIM_RST_MAINT 8'h00
`define MECIM_RST_LINE_MASK 8'hff
`define MECIM_RST_ERR_MASK 8'hff
`endif
